// ### logic/tcw_consts.svh
// register offsets, field positions and divider widths of the timer block
`ifndef TCW_CONSTS_SVH
`define TCW_CONSTS_SVH

`define TCW_CH_STRIDE     8'h40
`define TCW_OFS_CMD       6'h00
`define TCW_OFS_CFG       6'h04
`define TCW_OFS_COUNT     6'h10
`define TCW_OFS_CMP_A     6'h14
`define TCW_OFS_CMP_B     6'h18
`define TCW_OFS_PERIOD    6'h1C
`define TCW_OFS_FLAGS     6'h20
`define TCW_OFS_IRQ_SET   6'h24
`define TCW_OFS_IRQ_CLR   6'h28
`define TCW_OFS_IRQ_MASK  6'h2C
`define TCW_OFS_BLK_CMD   8'hC0
`define TCW_OFS_BLK_ROUTE 8'hC4

`define TCW_F_CLK_ON      0
`define TCW_F_CLK_OFF     1
`define TCW_F_SOFT_TRG    2
`define TCW_F_SYNC        0
`define TCW_F_CLKSEL      0
`define TCW_F_INVERT      3
`define TCW_F_BURST       4
`define TCW_F_HALT        6
`define TCW_F_GATE_OFF    7
`define TCW_F_EDGE        8
`define TCW_F_TRG_LINE    10
`define TCW_F_EVSRC       10
`define TCW_F_EVTRG_EN    12
`define TCW_F_PROFILE     13
`define TCW_F_PER_TRG     14
`define TCW_F_WAVE        15
`define TCW_F_A_CMP_A     16
`define TCW_F_A_PERIOD    18
`define TCW_F_A_EVENT     20
`define TCW_F_A_SOFT      22
`define TCW_F_B_CMP_B     24
`define TCW_F_B_PERIOD    26
`define TCW_F_B_EVENT     28
`define TCW_F_B_SOFT      30

`define TCW_FL_OVF        0
`define TCW_FL_CMP_A      2
`define TCW_FL_CMP_B      3
`define TCW_FL_PERIOD     4
`define TCW_FL_EVENT      7
`define TCW_FL_CLK_ON     16
`define TCW_FL_LINE_A     17
`define TCW_FL_LINE_B     18

`define TCW_PRE_W         10
`define TCW_DIV1_LOG      1
`define TCW_DIV2_LOG      3
`define TCW_DIV3_LOG      5
`define TCW_DIV4_LOG      7
`define TCW_DIV5_LOG      10
`define TCW_COUNT_TOP     16'hFFFF
`define TCW_RST_CFG       32'h0000_0000
`define TCW_RST_ROUTE     6'h00

`endif

// ### logic/tcw_pkg.sv
// types shared by the timer block and its bench
package tcw_pkg;
  `include "tcw_consts.svh"

  typedef enum logic [1:0] {
    TCW_ACT_NONE = 2'h0,
    TCW_ACT_SET  = 2'h1,
    TCW_ACT_CLR  = 2'h2,
    TCW_ACT_TGL  = 2'h3
  } tcw_act_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tcw_bus_t;

  typedef struct packed {
    logic [2:0] ext_clock_pin;
    logic [2:0] io_line_a;
    logic [2:0] io_line_b;
  } tcw_pin_in_t;

  typedef struct packed {
    logic [2:0] io_line_a;
    logic [2:0] io_line_a_oe;
    logic [2:0] io_line_b;
    logic [2:0] io_line_b_oe;
  } tcw_pin_out_t;

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] count_now;
    logic [15:0] compare_a;
    logic [15:0] compare_b;
    logic [15:0] period_limit;
    logic [7:0]  irq_mask;
    logic [7:0]  flags;
    logic        clk_on;
    logic        clk_run;
    logic        down;
    logic        line_a;
    logic        line_b;
    logic        ck_prev;
    logic        ev_prev;
    logic        pend;
  } tcw_chan_t;

  typedef struct packed {
    tcw_chan_t [2:0]        ch;
    logic [5:0]             route;
    logic [`TCW_PRE_W-1:0]  pre;
    logic [31:0]            rdata;
  } tcw_state_t;
endpackage

// ### logic/tcw_timer.sv
// three-channel 16-bit timer/counter with waveform outputs
//
// Operation
// - profile 01: triangle 0 up to FFFF, back
// - up/down profiles: trigger reverses count direction
// - profile 01: period match never triggers
// - profile 11: triangle 0 up to period limit
// - period match halts or gates off clock in waveform mode
// - event source and edge select; none disables
// - line B event input disables compare B
// - event always triggers in capture mode; in waveform mode only with trigger enable bit
// - sync and soft trigger usable in waveform
// - per-event set/clear/toggle actions on lines
// - line B actions only when line B output
// - three channels at 0x40 stride, block regs
// - compare A/B writable only in waveform mode
// - block command bit 0 triggers all channels
// - routing fields pick pin, none, other line A
// - clock off wins over clock on command
// - command bit 2: soft trigger, restart clock
// - capture configuration field layout
// - event selector: line B or chain clocks
// - profile codes: up, up/down, with auto-trigger
// - event with enable resets counter in up profiles, starts clock
// - trigger acts at next counter clock edge
`timescale 1ns/10ps
`include "tcw_consts.svh"
module tcw_timer (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire tcw_pkg::tcw_bus_t     bus,
  output      logic [31:0]           rd_data,
  input  wire tcw_pkg::tcw_pin_in_t  pins_in,
  output      tcw_pkg::tcw_pin_out_t pins_out
);
  import tcw_pkg::*;

  tcw_state_t  st;
  tcw_state_t  next_st;
  tcw_chan_t   c;
  tcw_chan_t   nc;
  logic [2:0]  chain;
  logic        sync_cmd;
  logic        wr_hit;
  logic        rd_hit;
  logic [5:0]  off;
  logic [31:0] cfg;
  logic        wave;
  logic        b_out;
  logic        sw;
  logic        ev_lvl;
  logic        ev;
  logic        ev_trg;
  logic [2:0]  csel;
  logic        ck_lvl;
  logic        gate;
  logic        tick;
  logic        dn;
  logic [15:0] nv;
  logic [15:0] top;
  logic        ma;
  logic        mb;
  logic        mc;
  logic        ovf;

  function automatic logic act(input logic cur, input logic [1:0] code);
    case (tcw_act_t'(code))
      TCW_ACT_SET: act = 1'b1;
      TCW_ACT_CLR: act = 1'b0;
      TCW_ACT_TGL: act = ~cur;
      default:     act = cur;
    endcase
  endfunction

  // an event with a non-zero action overrides whatever a weaker one chose
  function automatic logic out_pick(input logic cur, input logic prev,
                                    input logic en, input logic [1:0] code);
    out_pick = (en && code != 2'h0) ? act(cur, code) : prev;
  endfunction

  function automatic logic edge_hit(input logic prev, input logic now, input logic [1:0] sel);
    case (sel)
      2'h1:    edge_hit = now & ~prev;
      2'h2:    edge_hit = prev & ~now;
      2'h3:    edge_hit = prev ^ now;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic pre_tick(input logic [2:0] sel, input logic [`TCW_PRE_W-1:0] pre);
    case (sel)
      3'h0:    pre_tick = &pre[`TCW_DIV1_LOG-1:0];
      3'h1:    pre_tick = &pre[`TCW_DIV2_LOG-1:0];
      3'h2:    pre_tick = &pre[`TCW_DIV3_LOG-1:0];
      3'h3:    pre_tick = &pre[`TCW_DIV4_LOG-1:0];
      3'h4:    pre_tick = &pre[`TCW_DIV5_LOG-1:0];
      default: pre_tick = 1'b0;
    endcase
  endfunction

  function automatic logic route_pick(input logic [1:0] sel, input logic pin,
                                      input logic lo, input logic hi);
    case (sel)
      2'h0:    route_pick = pin;
      2'h2:    route_pick = lo;
      2'h3:    route_pick = hi;
      default: route_pick = 1'b0;
    endcase
  endfunction

  // returns {down, value}; turning at the ends steps away at once so
  // neither end value is held for two counter edges
  function automatic logic [16:0] updown_step(input logic [15:0] v, input logic [15:0] lim,
                                               input logic d);
    logic [15:0] r;
    logic        rd;
    r  = v;
    rd = d;
    if (lim == 16'h0000) begin
      r  = 16'h0000;
      rd = 1'b0;
    end else if (!d) begin
      if (v >= lim) begin
        rd = 1'b1;
        r  = v - 16'h0001;
      end else begin
        r  = v + 16'h0001;
      end
    end else begin
      if (v == 16'h0000) begin
        rd = 1'b0;
        r  = 16'h0001;
      end else begin
        r  = v - 16'h0001;
      end
    end
    updown_step = {rd, r};
  endfunction

  always_comb begin
    next_st       = st;
    next_st.rdata = 32'h0;
    next_st.pre   = st.pre + `TCW_PRE_W'(1);
    c      = st.ch[0];
    nc     = st.ch[0];
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    off    = bus.addr[5:0];
    cfg    = 32'h0;
    wave   = 1'b0;
    b_out  = 1'b0;
    sw     = 1'b0;
    ev_lvl = 1'b0;
    ev     = 1'b0;
    ev_trg = 1'b0;
    csel   = 3'h0;
    ck_lvl = 1'b0;
    gate   = 1'b0;
    tick   = 1'b0;
    dn     = 1'b0;
    nv     = 16'h0000;
    top    = `TCW_COUNT_TOP;
    ma     = 1'b0;
    mb     = 1'b0;
    mc     = 1'b0;
    ovf    = 1'b0;
    sync_cmd = bus.wr && bus.addr == `TCW_OFS_BLK_CMD && bus.wdata[`TCW_F_SYNC];
    if (bus.wr && bus.addr == `TCW_OFS_BLK_ROUTE) begin
      next_st.route = bus.wdata[5:0];
    end
    if (bus.rd && bus.addr == `TCW_OFS_BLK_ROUTE) begin
      next_st.rdata = {26'h0, st.route};
    end
    // chain clocks follow the other channels' line A in ascending order
    chain[0] = route_pick(st.route[1:0], pins_in.ext_clock_pin[0], st.ch[1].line_a, st.ch[2].line_a);
    chain[1] = route_pick(st.route[3:2], pins_in.ext_clock_pin[1], st.ch[0].line_a, st.ch[2].line_a);
    chain[2] = route_pick(st.route[5:4], pins_in.ext_clock_pin[2], st.ch[0].line_a, st.ch[1].line_a);

    for (int i = 0; i < 3; i++) begin
      c      = st.ch[i];
      nc     = c;
      cfg    = c.cfg;
      wave   = cfg[`TCW_F_WAVE];
      b_out  = wave && cfg[`TCW_F_EVSRC +: 2] != 2'h0;
      wr_hit = bus.wr && bus.addr[7:6] == 2'(i);
      rd_hit = bus.rd && bus.addr[7:6] == 2'(i);
      sw     = sync_cmd || (wr_hit && off == `TCW_OFS_CMD && bus.wdata[`TCW_F_SOFT_TRG]);

      if (rd_hit) begin
        case (off)
          `TCW_OFS_CFG:      next_st.rdata = cfg;
          `TCW_OFS_COUNT:    next_st.rdata = {16'h0, c.count_now};
          `TCW_OFS_CMP_A:    next_st.rdata = {16'h0, c.compare_a};
          `TCW_OFS_CMP_B:    next_st.rdata = {16'h0, c.compare_b};
          `TCW_OFS_PERIOD:   next_st.rdata = {16'h0, c.period_limit};
          `TCW_OFS_IRQ_MASK: next_st.rdata = {24'h0, c.irq_mask};
          `TCW_OFS_FLAGS: begin
            next_st.rdata                = {24'h0, c.flags};
            next_st.rdata[`TCW_FL_CLK_ON] = c.clk_on;
            next_st.rdata[`TCW_FL_LINE_A] = c.line_a;
            next_st.rdata[`TCW_FL_LINE_B] = c.line_b;
            // cleared on read; events below are applied later and win
            nc.flags = 8'h00;
          end
          default:           next_st.rdata = 32'h0;
        endcase
      end

      if (wr_hit) begin
        case (off)
          `TCW_OFS_CMD: begin
            if (bus.wdata[`TCW_F_CLK_OFF]) begin
              nc.clk_on = 1'b0;
            end else if (bus.wdata[`TCW_F_CLK_ON]) begin
              nc.clk_on = 1'b1;
            end
          end
          `TCW_OFS_CFG:      nc.cfg = bus.wdata;
          `TCW_OFS_CMP_A: begin
            if (wave) begin
              nc.compare_a = bus.wdata[15:0];
            end
          end
          `TCW_OFS_CMP_B: begin
            if (wave) begin
              nc.compare_b = bus.wdata[15:0];
            end
          end
          `TCW_OFS_PERIOD:   nc.period_limit = bus.wdata[15:0];
          `TCW_OFS_IRQ_SET:  nc.irq_mask = c.irq_mask | bus.wdata[7:0];
          `TCW_OFS_IRQ_CLR:  nc.irq_mask = c.irq_mask & ~bus.wdata[7:0];
          default:           nc.irq_mask = nc.irq_mask;
        endcase
      end

      // capture mode watches line A or B; waveform mode line B or a chain clock
      if (wave) begin
        if (cfg[`TCW_F_EVSRC +: 2] == 2'h0) begin
          ev_lvl = pins_in.io_line_b[i];
        end else begin
          ev_lvl = chain[2'(cfg[`TCW_F_EVSRC +: 2] - 2'h1)];
        end
      end else begin
        ev_lvl = cfg[`TCW_F_TRG_LINE] ? pins_in.io_line_a[i] : pins_in.io_line_b[i];
      end
      ev         = edge_hit(c.ev_prev, ev_lvl, cfg[`TCW_F_EDGE +: 2]);
      nc.ev_prev = ev_lvl;
      ev_trg     = ev && (!wave || cfg[`TCW_F_EVTRG_EN]);
      if (ev) begin
        nc.flags[`TCW_FL_EVENT] = 1'b1;
      end
      // the counter itself only moves on its next active edge
      if (sw || ev_trg) begin
        nc.pend = 1'b1;
        if (nc.clk_on) begin
          nc.clk_run = 1'b1;
        end
      end

      // counter clock: internal divider taps or a chain clock edge
      csel       = cfg[`TCW_F_CLKSEL +: 3];
      // internal selections must not index past the three chain clocks
      ck_lvl     = (csel > 3'h4) ? chain[2'(csel[1:0] - 2'h1)] : 1'b0;
      nc.ck_prev = ck_lvl;
      gate       = (cfg[`TCW_F_BURST +: 2] == 2'h0) ? 1'b1 : chain[2'(cfg[`TCW_F_BURST +: 2] - 2'h1)];
      if (csel < 3'h5) begin
        tick = gate && pre_tick(csel, st.pre);
      end else begin
        tick = gate && edge_hit(c.ck_prev, ck_lvl, cfg[`TCW_F_INVERT] ? 2'h2 : 2'h1);
      end
      ma  = 1'b0;
      mb  = 1'b0;
      mc  = 1'b0;
      ovf = 1'b0;

      if (tick && c.clk_on && (c.clk_run || c.pend)) begin
        dn = c.down;
        nv = c.count_now + 16'h0001;
        if (wave && cfg[`TCW_F_PROFILE]) begin
          top = cfg[`TCW_F_PER_TRG] ? c.period_limit : `TCW_COUNT_TOP;
          if (c.pend) begin
            dn = ~c.down;
          end
          {dn, nv} = updown_step(c.count_now, top, dn);
        end else if (c.pend) begin
          nv = 16'h0000;
        end else if (cfg[`TCW_F_PER_TRG] && c.count_now == c.period_limit) begin
          nv = 16'h0000;
        end else begin
          ovf = c.count_now == `TCW_COUNT_TOP;
        end
        nc.pend      = 1'b0;
        nc.count_now = nv;
        nc.down      = dn;
        ma = wave && nv == c.compare_a;
        mb = b_out && nv == c.compare_b;
        mc = nv == c.period_limit;
      end

      // in profile 01 a period match only halts or gates, never restarts
      if (mc && wave) begin
        if (cfg[`TCW_F_HALT]) begin
          nc.clk_run = 1'b0;
        end
        if (cfg[`TCW_F_GATE_OFF]) begin
          nc.clk_on  = 1'b0;
          nc.clk_run = 1'b0;
        end
      end
      if (ovf) begin
        nc.flags[`TCW_FL_OVF] = 1'b1;
      end
      if (ma) begin
        nc.flags[`TCW_FL_CMP_A] = 1'b1;
      end
      if (mb) begin
        nc.flags[`TCW_FL_CMP_B] = 1'b1;
      end
      if (mc) begin
        nc.flags[`TCW_FL_PERIOD] = 1'b1;
      end

      // priority: soft trigger, event, period match, compare
      if (wave) begin
        nc.line_a = out_pick(c.line_a,
                     out_pick(c.line_a,
                      out_pick(c.line_a,
                       out_pick(c.line_a, c.line_a, ma, cfg[`TCW_F_A_CMP_A +: 2]),
                       mc, cfg[`TCW_F_A_PERIOD +: 2]),
                      ev, cfg[`TCW_F_A_EVENT +: 2]),
                     sw, cfg[`TCW_F_A_SOFT +: 2]);
      end
      if (b_out) begin
        nc.line_b = out_pick(c.line_b,
                     out_pick(c.line_b,
                      out_pick(c.line_b,
                       out_pick(c.line_b, c.line_b, mb, cfg[`TCW_F_B_CMP_B +: 2]),
                       mc, cfg[`TCW_F_B_PERIOD +: 2]),
                      ev, cfg[`TCW_F_B_EVENT +: 2]),
                     sw, cfg[`TCW_F_B_SOFT +: 2]);
      end
      next_st.ch[i] = nc;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    rd_data  = st.rdata;
    pins_out = '0;
    for (int i = 0; i < 3; i++) begin
      pins_out.io_line_a[i]    = st.ch[i].line_a;
      pins_out.io_line_a_oe[i] = st.ch[i].cfg[`TCW_F_WAVE];
      pins_out.io_line_b[i]    = st.ch[i].line_b;
      pins_out.io_line_b_oe[i] = st.ch[i].cfg[`TCW_F_WAVE] &&
                                 st.ch[i].cfg[`TCW_F_EVSRC +: 2] != 2'h0;
    end
  end
endmodule

// ### testbench/tcw_timer_assertions.sv
// port-level checks of the timer block, bound to its top module
`timescale 1ns/10ps
module tcw_timer_assertions (
  input wire logic                  sys_clk,
  input wire logic                  rst,
  input wire tcw_pkg::tcw_bus_t     bus,
  input wire logic [31:0]           rd_data,
  input wire tcw_pkg::tcw_pin_in_t  pins_in,
  input wire tcw_pkg::tcw_pin_out_t pins_out
);
  import tcw_pkg::*;
  logic [31:0] cfg0;
  logic [15:0] cmpa0;
  logic [7:0]  mask0;
  logic [5:0]  route;

  // shadow of channel 0 and block registers, as software wrote them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg0  <= 32'h0;
      cmpa0 <= 16'h0;
      mask0 <= 8'h0;
      route <= 6'h0;
    end else if (bus.wr) begin
      if (bus.addr == 8'h04) cfg0 <= bus.wdata;
      if (bus.addr == 8'h14 && cfg0[15]) cmpa0 <= bus.wdata[15:0];
      if (bus.addr == 8'h24) mask0 <= mask0 | bus.wdata[7:0];
      if (bus.addr == 8'h28) mask0 <= mask0 & ~bus.wdata[7:0];
      if (bus.addr == 8'hC4) route <= bus.wdata[5:0];
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  rd_idle_a: assert property (!$past(bus.rd) |-> rd_data == 32'h0)
    else $error("read data not idle");
  wo_read_a: assert property ($past(bus.rd) && ($past(bus.addr) inside {8'h00, 8'h08, 8'h24, 8'h28, 8'hC0, 8'hFC})
    |-> rd_data == 32'h0) else $error("write-only or reserved read not zero");
  cfg_back_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h04 |-> rd_data == $past(cfg0))
    else $error("configuration readback wrong");
  cmpa_guard_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h14 |-> rd_data == {16'h0, $past(cmpa0)})
    else $error("compare a guard wrong");
  mask_back_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'h2C |-> rd_data == {24'h0, $past(mask0)})
    else $error("mask readback wrong");
  route_back_a: assert property ($past(bus.rd) && $past(bus.addr) == 8'hC4 |-> rd_data == {26'h0, $past(route)})
    else $error("routing readback wrong");
  count_width_a: assert property ($past(bus.rd) && $past(bus.addr[5:0]) == 6'h10 |-> rd_data[31:16] == 16'h0)
    else $error("counter upper bits set");
  line_a_dir_a: assert property (!$past(bus.wr) && !$past(bus.wr, 2) |-> pins_out.io_line_a_oe[0] == cfg0[15])
    else $error("line a direction wrong");
  line_b_dir_a: assert property (!$past(bus.wr) && !$past(bus.wr, 2)
    |-> pins_out.io_line_b_oe[0] == (cfg0[15] && cfg0[11:10] != 2'h0)) else $error("line b direction wrong");
endmodule

bind tcw_timer tcw_timer_assertions u_chk (
  .sys_clk (sys_clk),
  .rst     (rst),
  .bus     (bus),
  .rd_data (rd_data),
  .pins_in (pins_in),
  .pins_out(pins_out)
);

// ### testbench/tcw_far_side.sv
// far-side model: external clock pin and the two lines of each channel
`timescale 1ns/10ps
module tcw_far_side (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_run,
  input  wire logic [2:0]            ev_level,
  input  wire tcw_pkg::tcw_pin_out_t pins_out,
  output      tcw_pkg::tcw_pin_in_t  pins_in,
  output      logic [15:0]           rises
);
  import tcw_pkg::*;
  logic [1:0] div;
  logic       ck;
  logic       wob;

  // each clock level lasts three cycles, so every edge is seen
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div   <= 2'h0;
      ck    <= 1'b0;
      rises <= 16'h0;
      wob   <= 1'b0;
    end else begin
      wob <= ~wob;
      if (clk_run) begin
        div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (div == 2'h2) ck <= ~ck;
        if (div == 2'h2 && !ck) rises <= rises + 16'h1;
      end
    end
  end

  // clock stands still outside bursts; an undriven line A wobbles
  assign pins_in.ext_clock_pin = {2'b00, ck};
  assign pins_in.io_line_a = (pins_out.io_line_a & pins_out.io_line_a_oe) | ({3{wob}} & ~pins_out.io_line_a_oe);
  assign pins_in.io_line_b = (pins_out.io_line_b & pins_out.io_line_b_oe) | (ev_level & ~pins_out.io_line_b_oe);
endmodule

// ### testbench/testbench.sv
// self-checking bench of the three-channel timer
`timescale 1ns/10ps
module testbench;
  import tcw_pkg::*;
  logic         sys_clk;
  logic         rst;
  logic         clk_run;
  logic [2:0]   ev_level;
  tcw_bus_t     bus;
  logic [31:0]  rd_data;
  tcw_pin_in_t  pins_in;
  tcw_pin_out_t pins_out;
  logic [15:0]  rises;
  logic [31:0]  v, v1, v2, r, r2;
  logic [31:0]  cfg_m [3];
  logic [1:0]   acts [4] = '{2'h2, 2'h3, 2'h3, 2'h1};
  logic         lvl;
  int           failures, checks_done, i, e, p, d;

  tcw_timer u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rd_data(rd_data), .pins_in(pins_in), .pins_out(pins_out));
  tcw_far_side u_far (.sys_clk(sys_clk), .rst(rst), .clk_run(clk_run), .ev_level(ev_level), .pins_out(pins_out),
    .pins_in(pins_in), .rises(rises));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge sys_clk);
    bus <= '{a, dt, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    q = rd_data;
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    rd(a, q);
    chk(n, x, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    failures++;
    conclude();
  end

  initial begin
    bus = '0;
    rst = 1'b1;
    clk_run = 1'b0;
    ev_level = 3'h0;
    r = $urandom(32'h66de);
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    idle(1);
    rc("cfg_rst", 8'h44, 32'h0);
    rc("count_rst", 8'h10, 32'h0);
    for (i = 0; i < 3; i++) begin
      cfg_m[i] = $urandom;
      wr(8'(i * 64 + 4), cfg_m[i]);
    end
    for (i = 0; i < 3; i++) rc("cfg", 8'(i * 64 + 4), cfg_m[i]);
    // random settings may have moved line B; drive it to a known low level
    for (i = 0; i < 3; i++) wr(8'(i * 64 + 4), 32'h8000_8400);
    wr(8'hC0, 32'h1);
    rc("reserved", 8'h08, 32'h0);
    rc("blk_cmd", 8'hC0, 32'h0);
    r = $urandom;
    r2 = $urandom;
    wr(8'h24, r);
    wr(8'h28, r2);
    rc("mask", 8'h2C, {24'h0, r[7:0] & ~r2[7:0]});
    r = $urandom;
    wr(8'hC4, r);
    rc("route", 8'hC4, {26'h0, r[5:0]});
    wr(8'hC4, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, r);
    rc("cmp_a_capture", 8'h14, 32'h0);
    wr(8'h04, 32'h8000);
    wr(8'h14, r);
    rc("cmp_a_wave", 8'h14, {16'h0, r[15:0]});
    // up/down without period trigger must pass a small period limit
    wr(8'h1C, 32'h3);
    wr(8'h04, 32'hA000);
    wr(8'h00, 32'h5);
    idle(40);
    rd(8'h10, v);
    chk("no_period_trg", 32'h1, {31'h0, v > 32'h3});
    wr(8'h04, 32'h8005);
    wr(8'h00, 32'h5);
    @(posedge sys_clk);
    clk_run <= 1'b1;
    idle(60);
    @(posedge sys_clk);
    clk_run <= 1'b0;
    idle(8);
    rc("ext_ticks", 8'h10, {16'h0, rises - 16'h1});
    // one prescaler tick per read, so every read must move by one
    wr(8'h1C, 32'd40);
    wr(8'h04, 32'hE000);
    wr(8'h00, 32'h5);
    rd(8'h10, v1);
    rd(8'h10, v2);
    d = (v2 > v1) ? 1 : -1;
    p = v2;
    if (p == 40) d = -1;
    if (p == 0) d = 1;
    for (i = 0; i < 100 || p < 10 || p > 30; i++) begin
      rd(8'h10, v);
      chk("tri_step", p + d, v);
      if (v == 40) d = -1;
      if (v == 0) d = 1;
      p = v;
    end
    wr(8'h00, 32'h4);
    rd(8'h10, v1);
    rd(8'h10, v2);
    chk("reverse", v1 - d, v2);
    wr(8'h04, 32'hE080);
    idle(200);
    rc("halt_count", 8'h10, 32'd40);
    rd(8'h20, v);
    chk("clk_gated", 32'h0, v & 32'h10000);
    wr(8'h00, 32'h1);
    rd(8'h20, v);
    chk("clk_on", 32'h10000, v & 32'h10000);
    wr(8'h00, 32'h3);
    rd(8'h20, v);
    chk("clk_off_wins", 32'h0, v & 32'h10000);
    // halt on period match stops the count but leaves the clock enabled
    wr(8'h04, 32'hE040);
    wr(8'h00, 32'h5);
    idle(200);
    rc("halt_stop", 8'h10, 32'd40);
    rd(8'h20, v);
    chk("halt_clk_on", 32'h10000, v & 32'h10000);
    for (e = 0; e < 2; e++) begin
      for (i = 0; i < 3; i++) wr(8'(i * 64 + 4), 32'h8000 | ((2 - e) << 22));
      wr(8'hC0, 32'h1);
      chk("sync_lines", {29'h0, {3{e[0]}}}, {29'h0, pins_out.io_line_a});
    end
    lvl = 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(8'h04, 32'h8000 | ({30'h0, acts[i]} << 22));
      wr(8'h00, 32'h4);
      lvl = (acts[i] == 2'h1) ? 1'b1 : (acts[i] == 2'h2) ? 1'b0 : ~lvl;
      chk("line_a", {31'h0, lvl}, {31'h0, pins_out.io_line_a[0]});
    end
    for (e = 0; e < 4; e++) begin
      wr(8'h84, 32'h4000_8000 | (e << 8));
      rd(8'hA0, v);
      @(posedge sys_clk);
      ev_level <= 3'h4;
      idle(3);
      rd(8'hA0, v);
      chk("ev_rise", {24'h0, e[0], 7'h0}, v & 32'h80);
      @(posedge sys_clk);
      ev_level <= 3'h0;
      idle(3);
      rd(8'hA0, v);
      chk("ev_fall", {24'h0, e[1], 7'h0}, v & 32'h80);
    end
    chk("line_b_oe", 32'h0, {31'h0, pins_out.io_line_b_oe[2]});
    wr(8'h80, 32'h4);
    rd(8'hA0, v);
    chk("line_b_input", 32'h0, v & 32'h40000);
    wr(8'h84, 32'h4000_8400);
    wr(8'h80, 32'h4);
    rd(8'hA0, v);
    chk("line_b_output", 32'h40000, v & 32'h40000);
    conclude();
  end
endmodule
